// file: include/sgps_defs.svh
// Offsets, field positions, reset values and widths of the group selector
`ifndef SGPS_DEFS_SVH
`define SGPS_DEFS_SVH

// Bus widths
`define SGPS_ADDR_W      8
`define SGPS_DATA_W      32

// Group count and code width
`define SGPS_NGROUP      8
`define SGPS_CODE_W      4
`define SGPS_USED_W      3

// Register byte addresses
`define SGPS_ADDR_CTRL   8'h00
`define SGPS_ADDR_FORCE  8'h04
`define SGPS_ADDR_REMOTE 8'h08
`define SGPS_ADDR_STATUS 8'h0c

// Control register fields
`define SGPS_CTRL_OVR    0
`define SGPS_CTRL_USED_L 4
`define SGPS_CTRL_USED_H 6

// Status register fields
`define SGPS_STAT_CODE_L 0
`define SGPS_STAT_CODE_H 3
`define SGPS_STAT_OVR    4
`define SGPS_STAT_USED_L 5
`define SGPS_STAT_USED_H 7
`define SGPS_STAT_F_NC   8
`define SGPS_STAT_F_FRC  9
`define SGPS_STAT_F_LOW  10

// Encodings and reset values
`define SGPS_CODE_NONE   4'h0
`define SGPS_CODE_MAX    4'h8
`define SGPS_USED_RST    3'h0
`define SGPS_ACTIVE_RST  8'h01

`endif

// file: include/sgps_pkg.sv
// Types shared by the setting group selector
package sgps_pkg;

  // Software controlled settings
  typedef struct packed {
    logic       override;   // Operator owns selection
    logic [2:0] used;       // Enabled group count code
  } sgps_ctrl_t;

  // Sticky failure flags
  typedef struct packed {
    logic low_prio;   // Request lost to higher group
    logic force_bad;  // Forced change refused
    logic not_cfg;    // Request for disabled group
  } sgps_fail_t;

endpackage

// file: verilog/sgps_selector.sv
// Setting group priority selector with register port
//
// Overview of operation
// - Up to eight groups, exactly one active
// - Default: group one only, logic idle
// - Several enabled groups: inputs decide activation
// - Override set: automatic inputs ignored, operator rules
// - Requests accepted as pulses or levels
// - Simultaneous requests: group one ranks highest
// - Two static levels: higher priority wins
// - Pulse-selected group stays until another request
// - Override released: levels retake control immediately
// - Forced select: 0 none, 1..8 groups
// - Forcing is pulse mode only
// - No requests: last group stays active
// - Override 0/1, held until cleared, gates forcing
// - Used-count code n (0..7) enables groups 1..n+1
// - Remote change loses to held higher group
// - Group one level masks all other requests
// - Groups two..seven level mask lower groups
// - Group eight level blocks nothing
// - Inputs 0/1 inactive default; active group reported
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sgps_defs.svh"

module sgps_selector
  import sgps_pkg::*;
(
  // Clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  // Register port
  input  wire logic [`SGPS_ADDR_W-1:0]   ADDR,
  input  wire logic [`SGPS_DATA_W-1:0]   WR_DATA,
  input  wire logic                      WR_EN,
  input  wire logic                      RD_EN,
  output logic      [`SGPS_DATA_W-1:0]   RD_DATA,
  // Group activation inputs
  input  wire logic [`SGPS_NGROUP-1:0]   GROUP_REQ,
  // Selection outputs
  output logic      [`SGPS_NGROUP-1:0]   ACTIVE_GROUP,
  output logic      [`SGPS_NGROUP-1:0]   ENABLED_GROUPS,
  output logic                           OVERRIDE_ON
);

  ////////////////////////////////////////////////////////////////
  // Decode helpers

  // Group count code to enable mask
  // Code n enables groups one to n+1, so group one is never off
  function automatic logic [7:0] used_mask(
    input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(code)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Lowest index set wins, group one first
  // Scanning from the top down lets the last hit be the best group
  function automatic logic [7:0] pick_top(
    input logic [7:0] req);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        p = 8'h01 << i;
      end
    end
    return p;
  endfunction

  // Group code 1..8 to one-hot, none gives zero
  // Codes above eight also give zero, which callers treat as refusal
  function automatic logic [7:0] code_hot(
    input logic [3:0] code);
    logic [7:0] h;
    h = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (int'(code) == i + 1) begin
        h[i] = 1'b1;
      end
    end
    return h;
  endfunction

  // One-hot to group code 1..8
  // Only used for status readback; the active group is never zero
  function automatic logic [3:0] hot_code(
    input logic [7:0] hot);
    logic [3:0] c;
    c = `SGPS_CODE_NONE;
    for (int i = 0; i < 8; i++) begin
      if (hot[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Declarations

  sgps_ctrl_t ctrl;              // Override and used count
  sgps_fail_t fail;              // Sticky failure flags
  sgps_fail_t fail_set;          // Failure events this cycle
  logic [3:0] force_sel;         // Last accepted forced group
  logic [3:0] remote_sel;        // Last remote change code
  logic [7:0] en_mask;           // Enabled groups
  logic [7:0] req_en;            // Requests on enabled groups
  logic [7:0] rem_hot;           // Remote pulse request
  logic [7:0] frc_hot;           // Forced group one-hot
  logic [7:0] all_req;           // Inputs plus remote
  logic [7:0] winner;            // Resolved request
  logic [7:0] next_active;       // Active group next cycle
  logic       wr_ctrl;           // Control write strobe
  logic       wr_force;          // Force write strobe
  logic       wr_remote;         // Remote write strobe
  logic       wr_status;         // Status write strobe
  logic       force_ok;          // Forced write accepted
  logic [3:0] wr_code;           // Written group code

  ////////////////////////////////////////////////////////////////
  // Address decode

  // Write strobes per register
  // Exact compare, so unmapped addresses raise no strobe at all
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_force  = 1'b0;
    wr_remote = 1'b0;
    wr_status = 1'b0;
    if (!WR_EN) begin
      wr_ctrl = 1'b0;            // No write this cycle
    end else if (ADDR == `SGPS_ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (ADDR == `SGPS_ADDR_FORCE) begin
      wr_force = 1'b1;
    end else if (ADDR == `SGPS_ADDR_REMOTE) begin
      wr_remote = 1'b1;
    end else if (ADDR == `SGPS_ADDR_STATUS) begin
      wr_status = 1'b1;
    end
  end

  assign wr_code = WR_DATA[3:0];
  assign en_mask = used_mask(ctrl.used);

  ////////////////////////////////////////////////////////////////
  // Control register

  // Override held until software clears it
  // Shrinking the used count may disable the active group; with the override
  // clear and no enabled request, the priority block then falls back to group one
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl.override <= 1'b0;
      ctrl.used     <= `SGPS_USED_RST;
    end else if (wr_ctrl) begin
      ctrl.override <= WR_DATA[`SGPS_CTRL_OVR];
      ctrl.used     <= WR_DATA[`SGPS_CTRL_USED_H:`SGPS_CTRL_USED_L];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Forced selection

  // Accepted only with override set, valid code, enabled group
  // Code zero is accepted so software can drop a forced pick
  // without releasing the override
  assign frc_hot  = code_hot(wr_code);
  assign force_ok = wr_force && ctrl.override
                    && (wr_code <= `SGPS_CODE_MAX)
                    && ((frc_hot & en_mask) != 8'h00
                        || wr_code == `SGPS_CODE_NONE);

  // Falls back to none once override is released
  // Clearing on release keeps a stale pick from coming back
  // the next time the override is set
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      force_sel <= `SGPS_CODE_NONE;
    end else if (!ctrl.override) begin
      force_sel <= `SGPS_CODE_NONE;
    end else if (force_ok) begin
      force_sel <= wr_code;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Remote change

  // Remote write acts as a one-cycle request
  // Folded in as a pulse, so a held higher level still beats it
  // and a remote command cannot pull rank over the inputs
  assign rem_hot = (wr_remote && !ctrl.override)
                   ? code_hot(wr_code) & en_mask : 8'h00;

  // Last remote code kept for readback
  // Stored even under override so software sees its last command;
  // only the request itself is gated
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      remote_sel <= `SGPS_CODE_NONE;
    end else if (wr_remote) begin
      remote_sel <= wr_code;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Priority resolution

  // Requests outside the enabled set are dropped
  assign req_en  = GROUP_REQ & en_mask;
  assign all_req = req_en | rem_hot;
  // A held level on group n hides every group below n;
  // group eight hides nothing as nothing ranks lower
  assign winner  = pick_top(all_req);

  // Next active group and failure events
  // Holding is the default, so a pulse-picked group stays put
  always_comb begin
    next_active = ACTIVE_GROUP;
    fail_set    = '0;
    if (ctrl.override) begin
      // Operator only; inputs and remote ignored
      if (force_ok && frc_hot != 8'h00) begin
        next_active = frc_hot;
      end
      if (wr_force && !force_ok) begin
        fail_set.force_bad = 1'b1;
      end
    end else begin
      if (wr_force) begin
        fail_set.force_bad = 1'b1;
      end
      if (ctrl.used == `SGPS_USED_RST) begin
        next_active = `SGPS_ACTIVE_RST;
      end else if (winner != 8'h00) begin
        next_active = winner;
      end else if ((ACTIVE_GROUP & en_mask) == 8'h00) begin
        next_active = `SGPS_ACTIVE_RST;
      end
      // Remote request beaten by a held higher group
      if (rem_hot != 8'h00 && winner != rem_hot) begin
        fail_set.low_prio = 1'b1;
      end
      // Input requests that lost to a higher group
      if ((req_en & ~winner) != 8'h00) begin
        fail_set.low_prio = 1'b1;
      end
      // Requests for groups not enabled
      if ((GROUP_REQ & ~en_mask) != 8'h00) begin
        fail_set.not_cfg = 1'b1;
      end
      if (wr_remote && (code_hot(wr_code) & ~en_mask) != 8'h00) begin
        fail_set.not_cfg = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Active group

  // One-hot register, only ever loaded with one group
  // Every source of next_active is one-hot or a constant group,
  // so no separate repair logic is needed here
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ACTIVE_GROUP <= `SGPS_ACTIVE_RST;
    end else begin
      ACTIVE_GROUP <= next_active;
    end
  end

  // Mirrors of settings for downstream logic
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ENABLED_GROUPS <= `SGPS_ACTIVE_RST;
      OVERRIDE_ON    <= 1'b0;
    end else begin
      ENABLED_GROUPS <= en_mask;
      OVERRIDE_ON    <= ctrl.override;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Failure flags

  // Write one to clear; a new event beats the clear
  // Flags record lost or refused requests for software to poll;
  // the block raises no interrupt of its own
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fail <= '0;
    end else if (wr_status) begin
      fail.not_cfg   <= fail_set.not_cfg
                        | (fail.not_cfg & ~WR_DATA[`SGPS_STAT_F_NC]);
      fail.force_bad <= fail_set.force_bad
                        | (fail.force_bad & ~WR_DATA[`SGPS_STAT_F_FRC]);
      fail.low_prio  <= fail_set.low_prio
                        | (fail.low_prio & ~WR_DATA[`SGPS_STAT_F_LOW]);
    end else begin
      fail <= fail | fail_set;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data

  // Read strobe and address are sampled together, so a stray
  // address change without a strobe never shows on the bus
  // Data valid only in the cycle after the strobe;
  // unmapped addresses read as zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RD_DATA <= '0;
    end else if (!RD_EN) begin
      RD_DATA <= '0;
    end else if (ADDR == `SGPS_ADDR_CTRL) begin
      RD_DATA <= '0;
      RD_DATA[`SGPS_CTRL_OVR] <= ctrl.override;
      RD_DATA[`SGPS_CTRL_USED_H:`SGPS_CTRL_USED_L] <= ctrl.used;
    end else if (ADDR == `SGPS_ADDR_FORCE) begin
      RD_DATA <= {28'h0000000, force_sel};
    end else if (ADDR == `SGPS_ADDR_REMOTE) begin
      RD_DATA <= {28'h0000000, remote_sel};
    end else if (ADDR == `SGPS_ADDR_STATUS) begin
      RD_DATA <= '0;
      RD_DATA[`SGPS_STAT_CODE_H:`SGPS_STAT_CODE_L]
        <= hot_code(ACTIVE_GROUP);
      RD_DATA[`SGPS_STAT_OVR] <= ctrl.override;
      RD_DATA[`SGPS_STAT_USED_H:`SGPS_STAT_USED_L] <= ctrl.used;
      RD_DATA[`SGPS_STAT_F_NC]  <= fail.not_cfg;
      RD_DATA[`SGPS_STAT_F_FRC] <= fail.force_bad;
      RD_DATA[`SGPS_STAT_F_LOW] <= fail.low_prio;
    end else begin
      RD_DATA <= '0;
    end
  end

endmodule // sgps_selector

// file: test/sgps_req_src.sv
// Request source model: internal logic, digital inputs and panel
`timescale 1ns/1ps
module sgps_req_src (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Commands from the bench
  input  wire logic [7:0] level,     // Held requests
  input  wire logic [7:0] pulse,     // One-cycle requests
  // Toward the selector
  output logic      [7:0] group_req  // Bit 0 is group one
);
  // Registered like a filtered input, so pulses are one clean cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      group_req <= 8'h00;          // Idle is inactive
    end else begin
      group_req <= level | pulse;  // Levels and pulses share a line
    end
  end
endmodule  // sgps_req_src

// file: test/sgps_selector_assertions.sv
// Port assertions for the setting group selector
`timescale 1ns/1ps
module sgps_checker (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Register port
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic        WR_EN,
  input wire logic        RD_EN,
  input wire logic [31:0] RD_DATA,
  // Groups
  input wire logic [7:0]  GROUP_REQ,
  input wire logic [7:0]  ACTIVE_GROUP,
  input wire logic [7:0]  ENABLED_GROUPS,
  input wire logic        OVERRIDE_ON
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [7:0] hit;   // Enabled requests
  logic [7:0] low;   // Highest priority among them
  logic [1:0] wrs;   // Writes in the last two cycles
  logic       calm;  // Settled: a write moves state for two cycles
  logic [3:0] act_code;  // Active group as its 1..8 code
  // Group code of the active output, zero if none set
  always_comb begin
    act_code = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (ACTIVE_GROUP[i]) begin
        act_code = 4'(i + 1);
      end
    end
  end
  assign hit  = GROUP_REQ & ENABLED_GROUPS;
  assign low  = hit & (~hit + 8'h01);
  assign calm = !WR_EN && wrs == 2'h0;
  // Write history
  always_ff @(posedge CLK_SYS) wrs <= RST ? 2'h0 : {wrs[0], WR_EN};
  //////////////////////////////////////////////////////////////
  a_one_hot: assert property ($onehot(ACTIVE_GROUP))
    else $error("active not one-hot");
  a_reset_state: assert property (disable iff (1'b0)
    RST |=> ACTIVE_GROUP == 8'h01 && !OVERRIDE_ON) else $error("reset state wrong");
  a_prio_pick: assert property (
    !OVERRIDE_ON && calm && hit != 8'h00 |=> ACTIVE_GROUP == $past(low))
    else $error("wrong winner");
  a_idle_hold: assert property (!OVERRIDE_ON && calm && hit == 8'h00
    |=> $stable(ACTIVE_GROUP)) else $error("active moved idle");
  a_override_lock: assert property (OVERRIDE_ON && calm |=> $stable(ACTIVE_GROUP))
    else $error("active moved under override");
  a_override_keep: assert property (OVERRIDE_ON && calm |=> OVERRIDE_ON)
    else $error("override dropped");
  a_enable_mask: assert property (ENABLED_GROUPS[0]
    && (ENABLED_GROUPS & (ENABLED_GROUPS + 8'h01)) == 8'h00) else $error("bad mask");
  a_single_group: assert property (ENABLED_GROUPS == 8'h01 && calm
    |=> ACTIVE_GROUP == 8'h01) else $error("not group one");
  a_status_code: assert property (RD_EN && ADDR == 8'h0c
    |=> RD_DATA[3:0] == $past(act_code)) else $error("status code wrong");
endmodule  // sgps_checker

bind sgps_selector sgps_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
  .GROUP_REQ(GROUP_REQ), .ACTIVE_GROUP(ACTIVE_GROUP),
  .ENABLED_GROUPS(ENABLED_GROUPS), .OVERRIDE_ON(OVERRIDE_ON));

// file: test/sgps_selector_tb.sv
// Self-checking bench for the setting group selector
`timescale 1ns/1ps
module sgps_selector_tb;
  logic        clk = 1'b0;    // System clock
  logic        rst = 1'b1;    // Reset
  logic [7:0]  addr = 8'h00;  // Bus address
  logic [31:0] wdat = 32'h0;  // Write data
  logic        wen = 1'b0;    // Write strobe
  logic        ren = 1'b0;    // Read strobe
  logic [31:0] rdat;          // Read data
  logic [7:0]  lvl = 8'h00;   // Held requests
  logic [7:0]  pls = 8'h00;   // Pulse requests
  logic [7:0]  req;
  logic [7:0]  act;
  logic [7:0]  en;
  logic        ovr;
  int          err_total = 0;
  int          n_compared = 0;
  always #4 clk = ~clk;
  sgps_req_src src (.clk_sys(clk), .rst(rst), .level(lvl), .pulse(pls), .group_req(req));
  sgps_selector dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WR_DATA(wdat), .WR_EN(wen),
    .RD_EN(ren), .RD_DATA(rdat), .GROUP_REQ(req), .ACTIVE_GROUP(act),
    .ENABLED_GROUPS(en), .OVERRIDE_ON(ovr));
  //////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One write strobe cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wen  <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  // Read; data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    ren  <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1 chk("read", rdat & m, e);
  endtask
  // Bounded wait for an active group; a timeout ends the run
  task automatic wact(logic [7:0] e);
    int i;
    @(negedge clk);
    for (i = 0; i < 6 && act !== e; i++) @(negedge clk);
    chk("active", 32'(act), 32'(e));
    if (act !== e) conclude();
  endtask
  task automatic pulse(logic [7:0] g);
    @(posedge clk);
    pls <= g;
    @(posedge clk);
    pls <= 8'h00;
  endtask
  task automatic lv(logic [7:0] v);
    @(posedge clk);
    lvl <= v;
  endtask
  // Winner is the lowest set bit
  function automatic logic [7:0] top1(logic [7:0] x);
    return x & (~x + 8'h01);
  endfunction
  //////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    void'($urandom(51345));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("enabled", 32'(en), 32'h01);
    rd(8'h0c, 32'h7ff, 32'h001);
    rd(8'h04, 32'hf, 32'h0);
    rd(8'h10, 32'hffffffff, 32'h0);
    // Single group: requests for others go nowhere
    pulse(8'h04);
    repeat (3) @(negedge clk);
    chk("active", 32'(act), 32'h01);
    rd(8'h0c, 32'h100, 32'h100);
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 32'(k) << 4);
      repeat (2) @(negedge clk);
      chk("enabled", 32'(en), (32'h2 << k) - 32'h1);
    end
    pulse(8'h04);
    wact(8'h04);
    repeat (4) @(negedge clk);
    chk("active", 32'(act), 32'h04);
    pulse(8'h82);
    wact(8'h02);
    rd(8'h0c, 32'h4ff, 32'h4e2);
    // Random levels, group eight alone first
    for (int n = 0; n < 16; n++) begin
      r = (n == 0) ? 8'h80 : 8'($urandom | (1 << (n % 8)));
      lv(r);
      wact(top1(r));
    end
    lv(8'h00);
    repeat (3) @(negedge clk);
    chk("active", 32'(act), 32'(top1(r)));
    wr(8'h08, 32'h5);
    wact(8'h10);
    lv(8'h02);
    wact(8'h02);
    wr(8'h08, 32'h6);
    repeat (3) @(negedge clk);
    chk("active", 32'(act), 32'h02);
    rd(8'h08, 32'hf, 32'h6);
    wr(8'h04, 32'h6);
    repeat (3) @(negedge clk);
    chk("active", 32'(act), 32'h02);
    // Override first, then force a group
    wr(8'h00, 32'h71);
    wr(8'h0c, 32'h700);
    lv(8'h01);
    repeat (4) @(negedge clk);
    chk("active", 32'(act), 32'h02);
    chk("override", 32'(ovr), 32'h1);
    rd(8'h00, 32'h7f, 32'h71);
    wr(8'h04, 32'h4);
    wact(8'h08);
    wr(8'h04, 32'h9);
    repeat (3) @(negedge clk);
    rd(8'h0c, 32'h7ff, 32'h2f4);
    wr(8'h00, 32'h70);
    wact(8'h01);
    rd(8'h04, 32'hf, 32'h0);
    lv(8'h00);
    wr(8'h00, 32'h71);
    wr(8'h04, 32'h7);
    wact(8'h40);
    wr(8'h00, 32'h70);
    repeat (4) @(negedge clk);
    chk("active", 32'(act), 32'h40);
    wr(8'h00, 32'h20);
    wact(8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("enabled", 32'(en), 32'h01);
    conclude();
  end
endmodule  // sgps_selector_tb
